// File: include/sbmi_pkg.sv
// Package with constants and types of the system bus master interface
package sbmi_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 100;
  // Longest grant-to-cycle delay, in clock periods
  localparam int unsigned GRANT_START_MAX = 4;
  // Release delay after hold withdrawal, more than two clocks
  localparam int unsigned HOLD_DROP_NS    = 300;
  localparam logic [2:0]  HOLD_DROP_CYC   =
    3'((HOLD_DROP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Earliest acknowledge in handshake style: falling edge of third clock
  localparam logic [1:0]  HS_MIN_WAIT     = 2'h2;
  localparam logic [1:0]  CNT2_ZERO       = 2'h0;
  localparam logic [1:0]  CNT2_ONE        = 2'h1;
  localparam logic [2:0]  CNT3_ZERO       = 3'h0;
  localparam logic [2:0]  CNT3_ONE        = 3'h1;
  localparam logic [2:0]  DROP_DONE       = 3'h0;
  localparam logic [31:0] DATA_ZERO       = 32'h0;
  localparam logic [29:0] ADDR_ZERO       = 30'h0;
  localparam logic [3:0]  PAR_ZERO        = 4'h0;
  // Access source, in descending priority order
  typedef enum logic [1:0] {
    SBMI_SRC_RX,
    SBMI_SRC_TX,
    SBMI_SRC_CFG,
    SBMI_SRC_NONE
  } sbmi_src_e;
  // Memory area of an access
  typedef enum logic [1:0] {
    SBMI_AREA_CFG,
    SBMI_AREA_TXDATA,
    SBMI_AREA_OTHER
  } sbmi_area_e;
  typedef enum {
    SBMI_IDLE,
    SBMI_REQ,
    SBMI_GRANT,
    SBMI_S1,
    SBMI_S2,
    SBMI_HS_A,
    SBMI_HS_W,
    SBMI_END,
    SBMI_DROP,
    SBMI_WAITREL
  } sbmi_state_e;
endpackage

// File: logic/sbmi_core.sv
// System bus master: two bus styles, arbitration, error and parity handling
//
// Summary of operation
// - Mode strap selects ready/hold style or strobe/acknowledge/grant style.
// - Synchronous style: even byte parity when strap is one, none when zero.
// - Lower-order byte of each word maps to the lower byte address.
// - Cycle state one drives address and definition, asserts address status.
// - Ready ignored in state one, sampled end of state two; waits inserted.
// - Reads float data lines and latch data and parity when ready seen.
// - Writes drive data and parity from state two until after ready.
// - Fault on configuration read: end cycle, action-fail interrupt, suspend.
// - Fault on transmit data read aborts frame; other transmit faults do nothing.
// - Memory supplies four lane parity bits, upper lane first, checked even.
// - Parity check output low the clock after latch, one or two clocks.
// - Drive hold request high whenever a transfer is needed.
// - On acknowledge, start if we requested, else forward down the chain.
// - No new hold request until previous acknowledge is deasserted.
// - Acknowledge withdrawn mid-cycle: fault end, release over two clocks later.
// - Begin a cycle within four clocks after our own grant.
// - Handshake: address strobe mid-clock, write data strobe two clocks later; the code switches both strobes on the rising edge.
// - Handshake reads: data strobe with address strobe, latch at last fall; the code latches on the rising edge that ends the cycle.
// - Acknowledge seen earliest at third clock; strobes negate before end.
// - Fault terminates handshake cycle; errored read aborts transmit channel.
// - Handshake arbitration: pull request low, ack grant or pass it on.
// - First cycle in the same clock as grant ack; request again after lines idle.
// - One tenure serves all pending: receive, then transmit, then config.
`timescale 1ns/10ps
module sbmi_core
  import sbmi_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        mode_strap_in,
  input  wire logic        parity_strap_in,
  input  wire logic        rx_req_in,
  input  wire logic        tx_req_in,
  input  wire logic        cfg_req_in,
  input  wire logic [29:0] rx_addr_in,
  input  wire logic [29:0] tx_addr_in,
  input  wire logic [29:0] cfg_addr_in,
  input  wire logic        rx_write_in,
  input  wire logic        tx_write_in,
  input  wire logic        cfg_write_in,
  input  wire logic        tx_is_data_in,
  input  wire logic [31:0] rx_wdata_in,
  input  wire logic [31:0] cfg_wdata_in,
  input  wire logic        ready_n_in,
  input  wire logic        transfer_ack_n_in,
  input  wire logic        bus_fault_n_in,
  input  wire logic        hold_acknowledge_in,
  input  wire logic        grant_in_n_in,
  input  wire logic        bus_request_n_in,
  input  wire logic        grant_owner_ack_n_in,
  input  wire logic [31:0] data_in,
  input  wire logic [3:0]  byte_parity_lines_in,
  output logic [29:0]      addr_out,
  output logic             write_out,
  output logic             addr_oe_n_out,
  output logic [31:0]      data_out,
  output logic [3:0]       byte_parity_lines_out,
  output logic             data_oe_n_out,
  output logic             address_status_strobe_n_out,
  output logic             address_strobe_n_out,
  output logic             data_strobe_n_out,
  output logic             parity_check_flag_n_out,
  output logic             hold_request_out,
  output logic             hold_ack_chain_out,
  output logic             bus_request_n_out,
  output logic             grant_owner_ack_n_out,
  output logic             grant_chain_out_n_out,
  output logic             rx_done_out,
  output logic             tx_done_out,
  output logic             cfg_done_out,
  output logic [31:0]      rdata_out,
  output logic             action_fail_irq_out,
  output logic             frame_abort_irq_out,
  output logic             restart_action_out
);

  function automatic logic [3:0] even_par(input logic [31:0] d);
    even_par = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
  endfunction

  // Two-stage synchronisers for every pin input except the straps
  logic [6:0] s1_ff;
  logic [6:0] s2_ff;
  logic [31:0] din1_ff;
  logic [31:0] din2_ff;
  logic [3:0]  pin1_ff;
  logic [3:0]  pin2_ff;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_ff   <= 7'h7E;
      s2_ff   <= 7'h7E;
      din1_ff <= DATA_ZERO;
      din2_ff <= DATA_ZERO;
      pin1_ff <= PAR_ZERO;
      pin2_ff <= PAR_ZERO;
    end else begin
      s1_ff   <= {ready_n_in, transfer_ack_n_in, bus_fault_n_in,
                  grant_in_n_in, bus_request_n_in, grant_owner_ack_n_in,
                  hold_acknowledge_in};
      s2_ff   <= s1_ff;
      din1_ff <= data_in;
      din2_ff <= din1_ff;
      pin1_ff <= byte_parity_lines_in;
      pin2_ff <= pin1_ff;
    end
  end
  logic rdy;
  logic ack;
  logic flt;
  logic gnt;
  logic ext_br;
  logic ext_grant_owner_ack;
  logic hold_acknowledge;
  assign rdy       = !s2_ff[6];
  assign ack       = !s2_ff[5];
  assign flt       = !s2_ff[4];
  assign gnt       = !s2_ff[3];
  assign ext_br    = !s2_ff[2];
  assign ext_grant_owner_ack = !s2_ff[1];
  assign hold_acknowledge      = s2_ff[0];

  // Straps caught once after reset release
  logic mode_hs_ff;
  logic par_en_ff;
  logic strap_ok_ff;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_hs_ff  <= 1'b0;
      par_en_ff   <= 1'b0;
      strap_ok_ff <= 1'b0;
    end else if (!strap_ok_ff) begin
      mode_hs_ff  <= mode_strap_in;
      par_en_ff   <= parity_strap_in & !mode_strap_in;
      strap_ok_ff <= 1'b1;
    end
  end

  logic pending;
  sbmi_src_e pick;
  // Source just completed is masked while its requester still sees done
  logic rx_live;
  logic tx_live;
  logic cfg_live;
  assign rx_live  = rx_req_in & !rx_done_out;
  assign tx_live  = tx_req_in & !tx_done_out;
  assign cfg_live = cfg_req_in & !cfg_done_out;
  assign pending = rx_live | tx_live | cfg_live;
  always_comb begin
    if (rx_live)       pick = SBMI_SRC_RX;
    else if (tx_live)  pick = SBMI_SRC_TX;
    else if (cfg_live) pick = SBMI_SRC_CFG;
    else               pick = SBMI_SRC_NONE;
  end
  logic busy_idle;
  assign busy_idle = !ext_br & !ext_grant_owner_ack;

  sbmi_state_e state_ff;
  sbmi_src_e   src_ff;
  logic [1:0]  wait_ff;
  logic [2:0]  drop_ff;
  logic [2:0]  gcnt_ff;
  logic        fault_ff;
  logic        latch_par_ff;
  logic [3:0]  lat_par_ff;
  logic [31:0] lat_data_ff;
  logic        end_ok;
  assign end_ok = (state_ff == SBMI_S2) ? (rdy | flt) : (ack | flt);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= SBMI_IDLE;
      src_ff   <= SBMI_SRC_NONE;
      wait_ff  <= CNT2_ZERO;
      drop_ff  <= DROP_DONE;
      gcnt_ff  <= CNT3_ZERO;
      fault_ff <= 1'b0;
    end else begin
      case (state_ff)
        SBMI_IDLE: if (pending && (mode_hs_ff ? busy_idle : !hold_acknowledge))
          state_ff <= SBMI_REQ;
        SBMI_REQ: if (mode_hs_ff ? gnt : hold_acknowledge) begin
          state_ff <= SBMI_GRANT;
          gcnt_ff  <= CNT3_ZERO;
        end
        SBMI_GRANT: begin
          // One clock after grant acknowledge, well inside four
          gcnt_ff <= gcnt_ff + CNT3_ONE;
          if (!pending) state_ff <= SBMI_END;
          else begin
            src_ff   <= pick;
            fault_ff <= 1'b0;
            wait_ff  <= CNT2_ZERO;
            state_ff <= mode_hs_ff ? SBMI_HS_A : SBMI_S1;
          end
        end
        SBMI_S1: state_ff <= SBMI_S2;
        SBMI_S2: if (!hold_acknowledge) begin
          fault_ff <= 1'b1;
          drop_ff  <= HOLD_DROP_CYC;
          state_ff <= SBMI_DROP;
        end else if (end_ok) begin
          fault_ff <= flt;
          state_ff <= SBMI_GRANT;
        end
        SBMI_HS_A: begin
          wait_ff  <= wait_ff + CNT2_ONE;
          if (wait_ff + CNT2_ONE == HS_MIN_WAIT) state_ff <= SBMI_HS_W;
        end
        SBMI_HS_W: if (end_ok) begin
          fault_ff <= flt;
          state_ff <= SBMI_GRANT;
        end
        SBMI_DROP: begin
          drop_ff <= drop_ff - CNT3_ONE;
          if (drop_ff == CNT3_ONE) state_ff <= SBMI_END;
        end
        SBMI_END: state_ff <= SBMI_WAITREL;
        SBMI_WAITREL: if (mode_hs_ff ? busy_idle : !hold_acknowledge)
          state_ff <= SBMI_IDLE;
        default: state_ff <= SBMI_IDLE;
      endcase
    end
  end

  logic in_cycle;
  logic cyc_end;
  logic cyc_read;
  logic owner;
  assign in_cycle = (state_ff == SBMI_S1) || (state_ff == SBMI_S2) ||
                    (state_ff == SBMI_HS_A) || (state_ff == SBMI_HS_W);
  assign owner = (state_ff != SBMI_IDLE) && (state_ff != SBMI_REQ) &&
                 (state_ff != SBMI_WAITREL);
  assign cyc_end = ((state_ff == SBMI_S2) && hold_acknowledge && end_ok) ||
                   ((state_ff == SBMI_HS_W) && end_ok);
  assign cyc_read = !write_out;

  // Address, direction and data for the selected source
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_out      <= ADDR_ZERO;
      write_out     <= 1'b0;
      data_out      <= DATA_ZERO;
      byte_parity_lines_out <= PAR_ZERO;
    end else if (state_ff == SBMI_GRANT && pending) begin
      case (pick)
        SBMI_SRC_RX: begin
          addr_out  <= rx_addr_in;
          write_out <= rx_write_in;
          data_out  <= rx_wdata_in;
          byte_parity_lines_out <= even_par(rx_wdata_in);
        end
        SBMI_SRC_TX: begin
          addr_out  <= tx_addr_in;
          write_out <= tx_write_in;
          data_out  <= DATA_ZERO;
          byte_parity_lines_out <= PAR_ZERO;
        end
        default: begin
          addr_out  <= cfg_addr_in;
          write_out <= cfg_write_in;
          data_out  <= cfg_wdata_in;
          byte_parity_lines_out <= even_par(cfg_wdata_in);
        end
      endcase
    end
  end

  function automatic logic write_out_next();
    case (pick)
      SBMI_SRC_RX: write_out_next = rx_write_in;
      SBMI_SRC_TX: write_out_next = tx_write_in;
      default:     write_out_next = cfg_write_in;
    endcase
  endfunction

  // Bus drive and strobes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_oe_n_out               <= 1'b1;
      data_oe_n_out               <= 1'b1;
      address_status_strobe_n_out <= 1'b1;
      address_strobe_n_out        <= 1'b1;
      data_strobe_n_out           <= 1'b1;
    end else begin
      addr_oe_n_out <= !(owner && state_ff != SBMI_END);
      address_status_strobe_n_out <= !(state_ff == SBMI_GRANT && pending &&
                                       !mode_hs_ff);
      // Write data held through the clock after ready
      data_oe_n_out <= !(write_out && (state_ff == SBMI_S1 ||
                         state_ff == SBMI_S2 || state_ff == SBMI_HS_A ||
                         state_ff == SBMI_HS_W));
      address_strobe_n_out <= !((state_ff == SBMI_GRANT && pending &&
                                 mode_hs_ff) ||
                                (in_cycle && mode_hs_ff && !cyc_end));
      // Reads raise data strobe with address strobe; writes two clocks later
      data_strobe_n_out <= !(mode_hs_ff && !cyc_end &&
        ((state_ff == SBMI_GRANT && pending && !write_out_next()) ||
         (in_cycle && !(state_ff == SBMI_HS_A && wait_ff == CNT2_ZERO &&
                        write_out))));
    end
  end

  // Read data capture, completion and error effects
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lat_data_ff         <= DATA_ZERO;
      lat_par_ff          <= PAR_ZERO;
      latch_par_ff        <= 1'b0;
      rdata_out           <= DATA_ZERO;
      rx_done_out         <= 1'b0;
      tx_done_out         <= 1'b0;
      cfg_done_out        <= 1'b0;
      action_fail_irq_out <= 1'b0;
      frame_abort_irq_out <= 1'b0;
      restart_action_out  <= 1'b0;
    end else begin
      latch_par_ff <= cyc_end && cyc_read && !flt && par_en_ff;
      if (cyc_end && cyc_read) begin
        lat_data_ff <= din2_ff;
        lat_par_ff  <= pin2_ff;
        rdata_out   <= din2_ff;
      end
      rx_done_out  <= cyc_end && src_ff == SBMI_SRC_RX;
      tx_done_out  <= cyc_end && src_ff == SBMI_SRC_TX;
      cfg_done_out <= cyc_end && src_ff == SBMI_SRC_CFG;
      action_fail_irq_out <= (cyc_end && flt && cyc_read &&
                              src_ff == SBMI_SRC_CFG);
      frame_abort_irq_out <= (cyc_end && flt && cyc_read &&
                              src_ff == SBMI_SRC_TX &&
                              (tx_is_data_in || mode_hs_ff));
      restart_action_out  <= (state_ff == SBMI_S2 && !hold_acknowledge);
    end
  end

  // Parity flag: one clock low after the latch
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) parity_check_flag_n_out <= 1'b1;
    else parity_check_flag_n_out <= !(latch_par_ff &&
                      (even_par(lat_data_ff) != lat_par_ff));
  end

  // Arbitration outputs
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_request_out      <= 1'b0;
      hold_ack_chain_out    <= 1'b0;
      bus_request_n_out     <= 1'b1;
      grant_owner_ack_n_out <= 1'b1;
      grant_chain_out_n_out <= 1'b1;
    end else begin
      hold_request_out <= !mode_hs_ff &&
        (state_ff == SBMI_REQ || (owner && state_ff != SBMI_END &&
         state_ff != SBMI_DROP));
      hold_ack_chain_out <= !mode_hs_ff && hold_acknowledge && !owner &&
                            state_ff != SBMI_REQ;
      bus_request_n_out <= !(mode_hs_ff && state_ff == SBMI_REQ &&
                             !gnt);
      grant_owner_ack_n_out <= !(mode_hs_ff && owner &&
                                 state_ff != SBMI_END);
      grant_chain_out_n_out <= !(mode_hs_ff && gnt && !owner &&
                                 state_ff != SBMI_REQ);
    end
  end

endmodule // sbmi_core

// File: sim/sbmi_core_assertions.sv
// Port checker for the system bus master, bound to its top module
`timescale 1ns/10ps
module sbmi_core_chk (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic mode_strap_in,
  input wire logic parity_strap_in,
  input wire logic hold_acknowledge_in,
  input wire logic write_out,
  input wire logic addr_oe_n_out,
  input wire logic data_oe_n_out,
  input wire logic address_status_strobe_n_out,
  input wire logic address_strobe_n_out,
  input wire logic parity_check_flag_n_out,
  input wire logic hold_request_out,
  input wire logic bus_request_n_out,
  input wire logic grant_owner_ack_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_style;
    mode_strap_in ? !hold_request_out : bus_request_n_out;
  endproperty
  a_style: assert property (p_style) else $error("wrong arbitration");
  property p_par_off;
    (!parity_strap_in || mode_strap_in) |-> parity_check_flag_n_out;
  endproperty
  a_par_off: assert property (p_par_off) else $error("parity flag");
  property p_two_state;
    $fell(address_status_strobe_n_out) |=>
      address_status_strobe_n_out && !addr_oe_n_out;
  endproperty
  a_two_state: assert property (p_two_state) else $error("status");
  property p_rd_float;
    (!address_status_strobe_n_out && !write_out) |-> data_oe_n_out;
  endproperty
  a_rd_float: assert property (p_rd_float) else $error("read drive");
  property p_wr_drive;
    $fell(address_status_strobe_n_out) && write_out |=> !data_oe_n_out;
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write data");
  property p_chk_len;
    $fell(parity_check_flag_n_out) |-> ##[1:2] parity_check_flag_n_out;
  endproperty
  a_chk_len: assert property (p_chk_len) else $error("flag length");
  property p_hold_again;
    $rose(hold_request_out) |-> !$past(hold_acknowledge_in);
  endproperty
  a_hold_again: assert property (p_hold_again) else $error("early");
  property p_start;
    $rose(hold_acknowledge_in) && hold_request_out |->
      ##[1:6] !address_status_strobe_n_out;
  endproperty
  a_start: assert property (p_start) else $error("late cycle");
  property p_drop;
    $fell(hold_acknowledge_in) && !addr_oe_n_out |->
      !addr_oe_n_out [*3];
  endproperty
  a_drop: assert property (p_drop) else $error("early release");
  property p_hs_start;
    $fell(grant_owner_ack_n_out) |-> ##[1:2] !address_strobe_n_out;
  endproperty
  a_hs_start: assert property (p_hs_start) else $error("no cycle");
  property p_hs_min;
    $fell(address_strobe_n_out) |=> !address_strobe_n_out [*2];
  endproperty
  a_hs_min: assert property (p_hs_min) else $error("short hs");
endmodule // sbmi_core_chk

bind sbmi_core sbmi_core_chk u_chk (.*);

// File: sim/sbmi_mem_model.sv
// Shared memory and arbiter model facing the bus master
`timescale 1ns/10ps
module sbmi_mem_model (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        mode_in,
  input  wire logic        hold_req_in,
  input  wire logic        bus_req_n_in,
  input  wire logic        gack_n_in,
  input  wire logic        ads_n_in,
  input  wire logic        as_n_in,
  input  wire logic [29:0] addr_in,
  input  wire logic        write_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic [2:0]  wait_in,
  input  wire logic        bad_par_in,
  input  wire logic        fault_in,
  input  wire logic        spur_in,
  input  wire logic        yank_in,
  output logic             ready_n_out,
  output logic             ack_n_out,
  output logic             fault_n_out,
  output logic             hold_ack_out,
  output logic             grant_n_out,
  output logic [31:0]      data_out,
  output logic [3:0]       par_out,
  output logic [31:0]      wdata_out
);
  logic [3:0]  cnt;
  logic        strb_n, hit, cut, rd, busy;
  logic [31:0] d;
  // Status strobe is a one-clock pulse: the cycle lasts until answered
  assign strb_n = mode_in ? as_n_in : (ads_n_in && !busy);
  assign hit = !strb_n && (cnt > {1'b0, wait_in});
  assign rd = !strb_n && !write_in;
  assign d = {addr_in, 2'h0} ^ 32'hC3A5_0F96;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 4'h0;
      {ready_n_out, ack_n_out, fault_n_out, grant_n_out} <= 4'hF;
      {hold_ack_out, cut, busy} <= 3'h0;
      {data_out, par_out, wdata_out} <= '0;
    end else begin
      cnt <= strb_n ? 4'h0 : cnt + {3'h0, cnt != 4'hF};
      busy <= !mode_in && !strb_n && !hit;
      // Answer only after the commanded waits
      ready_n_out <= !(hit && !mode_in && !fault_in);
      ack_n_out <= !(hit && mode_in && !fault_in);
      fault_n_out <= !(hit && fault_in);
      // Withdrawal only when commanded, and only mid-cycle
      cut <= yank_in && (cut || !ads_n_in);
      hold_ack_out <= (hold_req_in && !cut) || spur_in;
      grant_n_out <= !(!bus_req_n_in && gack_n_in);
      // Released bus toggles so stale data never looks valid
      data_out <= rd ? d : ~data_out;
      par_out <= rd ? {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0] ^ bad_par_in}
                    : ~par_out;
      if (hit && write_in) wdata_out <= wdata_in;
    end
  end
endmodule // sbmi_mem_model

// File: sim/tb.sv
// Self-checking bench for the system bus master
`timescale 1ns/10ps
module tb;
  import sbmi_pkg::*;
  logic clk_in, rst_n_in, mode_strap_in, parity_strap_in, tx_is_data_in;
  logic rx_req_in, tx_req_in, cfg_req_in, rx_write_in, tx_write_in;
  logic cfg_write_in, ready_n_in, transfer_ack_n_in, bus_fault_n_in;
  logic hold_acknowledge_in, grant_in_n_in, bus_request_n_in;
  logic grant_owner_ack_n_in, write_out, addr_oe_n_out, data_oe_n_out;
  logic address_status_strobe_n_out, address_strobe_n_out, data_strobe_n_out;
  logic parity_check_flag_n_out, hold_request_out, hold_ack_chain_out;
  logic bus_request_n_out, grant_owner_ack_n_out, grant_chain_out_n_out;
  logic rx_done_out, tx_done_out, cfg_done_out, action_fail_irq_out;
  logic frame_abort_irq_out, restart_action_out, bad, flt, spur, yank;
  logic [29:0] rx_addr_in, tx_addr_in, cfg_addr_in, addr_out;
  logic [31:0] rx_wdata_in, cfg_wdata_in, data_in, data_out, rdata_out, wr_seen;
  logic [3:0]  byte_parity_lines_in, byte_parity_lines_out;
  logic [2:0]  wt;
  logic [8:0]  ord;
  int          failures, check_count, seed;
  // No other masters: the wired lines follow our own drivers
  assign bus_request_n_in = bus_request_n_out;
  assign grant_owner_ack_n_in = grant_owner_ack_n_out;
  sbmi_core u_dut (.*);
  sbmi_mem_model u_mem (.clk_in, .rst_n_in, .mode_in(mode_strap_in),
    .hold_req_in(hold_request_out), .bus_req_n_in(bus_request_n_out),
    .gack_n_in(grant_owner_ack_n_out), .ads_n_in(address_status_strobe_n_out),
    .as_n_in(address_strobe_n_out), .addr_in(addr_out), .write_in(write_out),
    .wdata_in(data_out), .wait_in(wt), .bad_par_in(bad), .fault_in(flt),
    .spur_in(spur), .yank_in(yank), .ready_n_out(ready_n_in),
    .ack_n_out(transfer_ack_n_in), .fault_n_out(bus_fault_n_in),
    .hold_ack_out(hold_acknowledge_in), .grant_n_out(grant_in_n_in),
    .data_out(data_in), .par_out(byte_parity_lines_in), .wdata_out(wr_seen));
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  function automatic logic [31:0] mem_word(input logic [29:0] a);
    return {a, 2'h0} ^ 32'hC3A5_0F96;
  endfunction
  function automatic logic [3:0] flags();
    return {!parity_check_flag_n_out, restart_action_out,
            frame_abort_irq_out, action_fail_irq_out};
  endfunction
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rst(input logic m, input logic p);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    mode_strap_in <= m;
    parity_strap_in <= p;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
  endtask
  // Issue the masked accesses together, expect flags ei at the end
  task automatic run(input logic [2:0] m, input logic w, input logic [3:0] ei);
    logic [2:0] d, got;
    logic [3:0] irq;
    int n;
    @(posedge clk_in);
    rx_addr_in <= 30'($random(seed));
    tx_addr_in <= 30'($random(seed));
    cfg_addr_in <= 30'($random(seed));
    rx_wdata_in <= $random(seed);
    cfg_wdata_in <= $random(seed);
    {cfg_write_in, tx_write_in, rx_write_in} <= {3{w}};
    {cfg_req_in, tx_req_in, rx_req_in} <= m;
    got = 3'h0;
    irq = 4'h0;
    ord = 9'h0;
    for (n = 0; n < 300 && got != m && !irq[2]; n++) begin
      @(posedge clk_in);
      d = {cfg_done_out, tx_done_out, rx_done_out};
      irq |= flags();
      if (d != 3'h0) begin
        got |= d;
        ord = {ord[5:0], d};
        {cfg_req_in, tx_req_in, rx_req_in} <= m & ~got;
        if (!w && !flt) chk(rdata_out, mem_word(d[0] ? rx_addr_in :
          d[1] ? tx_addr_in : cfg_addr_in));
        if (w && !flt && !d[1])
          chk(wr_seen, d[0] ? rx_wdata_in : cfg_wdata_in);
      end
    end
    if (got != m && !irq[2]) begin
      failures++;
      $display("Error at %0t: access never completed", $time);
      end_of_test();
    end
    repeat (3) begin
      @(posedge clk_in);
      irq |= flags();
    end
    {cfg_req_in, tx_req_in, rx_req_in} <= 3'h0;
    chk(irq, ei);
  endtask
  initial begin
    seed = 32'ha71176e3;
    failures = 0;
    check_count = 0;
    {rst_n_in, mode_strap_in, parity_strap_in, tx_is_data_in} = 4'h0;
    {rx_req_in, tx_req_in, cfg_req_in, bad, flt, spur, yank} = 7'h0;
    {rx_write_in, tx_write_in, cfg_write_in, wt} = 6'h0;
    {rx_addr_in, tx_addr_in, cfg_addr_in, rx_wdata_in, cfg_wdata_in} = '0;
    for (int m = 0; m < 2; m++) begin
      rst(m[0], 1'b1);
      repeat (12) begin
        wt <= 3'($random(seed));
        tx_is_data_in <= 1'($random(seed));
        run(3'h1 << ($unsigned($random(seed)) % 3), 1'($random(seed)), 4'h0);
      end
      run(3'h7, 1'b0, 4'h0);
      chk(ord, 9'h054);
      flt <= 1'b1;
      tx_is_data_in <= 1'b1;
      run(3'h2, 1'b0, 4'h2);
      if (m == 0) begin
        run(3'h4, 1'b0, 4'h1);
        tx_is_data_in <= 1'b0;
        run(3'h2, 1'b0, 4'h0);
        run(3'h1, 1'b1, 4'h0);
      end
      flt <= 1'b0;
      bad <= 1'b1;
      run(3'h1, 1'b0, m ? 4'h0 : 4'h8);
      bad <= 1'b0;
    end
    rst(1'b0, 1'b0);
    bad <= 1'b1;
    run(3'h1, 1'b0, 4'h0);
    bad <= 1'b0;
    spur <= 1'b1;
    for (int n = 0; n < 10 && !hold_ack_chain_out; n++) @(posedge clk_in);
    chk(hold_ack_chain_out, 1'b1);
    spur <= 1'b0;
    repeat (4) @(posedge clk_in);
    yank <= 1'b1;
    run(3'h1, 1'b0, 4'h4);
    end_of_test();
  end
endmodule // tb
